//--- src/afr_fault_map.vh
// Register offsets, field positions, reset values and state codes for the
// amplifier fault-report control block. Definitions only.
`ifndef AFR_FAULT_MAP_VH
`define AFR_FAULT_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AFR_OFS_PIN_CTRL_A     8'h74
`define AFR_OFS_PIN_CTRL_B     8'h75
`define AFR_OFS_MISC_CTRL      8'h76
`define AFR_OFS_FAULT_CLEAR    8'h78
`define AFR_OFS_STATUS         8'h79

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AFR_RST_PIN_CTRL_A     8'h00
`define AFR_RST_PIN_CTRL_B     8'hF8
`define AFR_RST_MISC_CTRL      8'h00
`define AFR_RST_BYTE           8'h00
`define AFR_RST_BIT            1'h0

// ----------------------------------------
// Pin control A field positions
// ----------------------------------------
`define AFR_A_MASK_OVERTEMP_SHUTDOWN        7
`define AFR_A_MASK_CLK         4
`define AFR_A_MASK_UV          3
`define AFR_A_MASK_OV          2
`define AFR_A_MASK_OUTPUT_DIRECT_CURRENT          1
`define AFR_A_MASK_OVERCURRENT          0

// ----------------------------------------
// Pin control B / misc / clear positions
// ----------------------------------------
`define AFR_B_HOLD_CLK         5
`define AFR_B_HOLD_OTSD        4
`define AFR_B_HOLD_OTW         3
`define AFR_B_MASK_OVERTEMP_WARNING         2
`define AFR_M_CLK_DET_HOLD     7
`define AFR_M_OT_AUTO_REC      4
`define AFR_C_ANALOG_CLEAR     7

// ----------------------------------------
// Fault vector index (status byte layout)
// ----------------------------------------
`define AFR_NFLT               7
`define AFR_F_OC               0
`define AFR_F_DC               1
`define AFR_F_OV               2
`define AFR_F_UV               3
`define AFR_F_CLK              4
`define AFR_F_OTW              5
`define AFR_F_OTSD             6

// ----------------------------------------
// Fault flag modes
// ----------------------------------------
`define AFR_MODE_TRACK         2'h0
`define AFR_MODE_HOLD          2'h1
`define AFR_MODE_AUTOREC       2'h2

`endif

//--- src/afr_fault_flag.v
// One fault status flag: rising-edge set, track or hold, clear command.
// Assumes condition input is synchronous to core_clk.
`timescale 1ns/1ps
`include "afr_fault_map.vh"

module afr_fault_flag
(
   input  wire       core_clk,
   input  wire       rst_b,
   input  wire       cond,
   input  wire [1:0] mode,
   input  wire       clearCmd,
   output reg        flag
);

   reg condPrev;
   reg next_flag;
   wire newEvent;

   assign newEvent = cond & ~condPrev;

   always @*
   begin
      case (mode)
         `AFR_MODE_TRACK:
         begin
            // Live condition, but a clear blanks a persisting fault
            if (newEvent)
               next_flag = 1'b1;
            else if (clearCmd | ~cond)
               next_flag = 1'b0;
            else
               next_flag = flag;
         end
         `AFR_MODE_HOLD:
         begin
            // Set wins over clear
            if (newEvent)
               next_flag = 1'b1;
            else if (clearCmd)
               next_flag = 1'b0;
            else
               next_flag = flag;
         end
         `AFR_MODE_AUTOREC:
         begin
            if (newEvent)
               next_flag = 1'b1;
            else if (clearCmd | ~cond)
               next_flag = 1'b0;
            else
               next_flag = flag;
         end
         default:
            next_flag = flag;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         condPrev <= `AFR_RST_BIT;
         flag     <= `AFR_RST_BIT;
      end
      else
      begin
         condPrev <= cond;
         flag     <= next_flag;
      end
   end

endmodule

//--- src/afr_fault_ctrl.v
// Fault-report control: masks, hold enables, clear command, fault pin.
// Assumes a simple synchronous byte register port and sync fault inputs.
`timescale 1ns/1ps
`include "afr_fault_map.vh"

module afr_fault_ctrl
(
   input  wire       core_clk,
   input  wire       rst_b,
   input  wire       regWrite,
   input  wire       regRead,
   input  wire [7:0] regAddr,
   input  wire [7:0] regWdata,
   output reg  [7:0] regRdata,
   input  wire       faultOvercurrent,
   input  wire       faultOutputDc,
   input  wire       faultSupplyOver,
   input  wire       faultSupplyUnder,
   input  wire       faultClock,
   input  wire       warnOvertemp,
   input  wire       faultOvertemp,
   input  wire       clockDetect,
   output reg        faultPinActive,
   output reg        outputHighZ,
   output reg        clockDetectStatus
);

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   reg  [7:0]             fault_pin_control_a;
   reg  [7:0]             fault_pin_control_b;
   reg  [7:0]             misc_fault_control;
   reg                    clearPulse;
   reg                    next_clockDetectStatus;
   reg                    next_faultPinActive;
   reg                    next_outputHighZ;
   reg  [7:0]             next_regRdata;

   wire [`AFR_NFLT-1:0]   condVec;
   wire [`AFR_NFLT-1:0]   flagVec;
   wire [`AFR_NFLT-1:0]   maskVec;
   wire [`AFR_NFLT*2-1:0] modeVec;
   wire                   anyReport;
   wire                   stageStop;
   wire                   wrPinCtrlA;
   wire                   wrPinCtrlB;
   wire                   wrMiscCtrl;
   wire                   wrFaultClear;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   function [1:0] holdMode;
      input holdEn;
      begin
         holdMode = holdEn ? `AFR_MODE_HOLD : `AFR_MODE_TRACK;
      end
   endfunction

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   assign wrPinCtrlA   = regWrite & hit(regAddr, `AFR_OFS_PIN_CTRL_A);
   assign wrPinCtrlB   = regWrite & hit(regAddr, `AFR_OFS_PIN_CTRL_B);
   assign wrMiscCtrl   = regWrite & hit(regAddr, `AFR_OFS_MISC_CTRL);
   // Clear command is a one-shot pulse; its bit never stores
   assign wrFaultClear = regWrite & hit(regAddr, `AFR_OFS_FAULT_CLEAR);

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         fault_pin_control_a <= `AFR_RST_PIN_CTRL_A;
         fault_pin_control_b <= `AFR_RST_PIN_CTRL_B;
         misc_fault_control  <= `AFR_RST_MISC_CTRL;
         clearPulse          <= `AFR_RST_BIT;
      end
      else
      begin
         if (wrPinCtrlA)
            fault_pin_control_a <= regWdata;
         if (wrPinCtrlB)
            fault_pin_control_b <= regWdata;
         if (wrMiscCtrl)
            misc_fault_control <= regWdata;
         clearPulse <= wrFaultClear & regWdata[`AFR_C_ANALOG_CLEAR];
      end
   end

   // ----------------------------------------
   // Fault flags
   // ----------------------------------------
   assign condVec = {faultOvertemp, warnOvertemp, faultClock, faultSupplyUnder,
                     faultSupplyOver, faultOutputDc, faultOvercurrent};

   // Supply/current faults: flagged until clear or removal
   assign modeVec[`AFR_F_OC*2 +: 2] = `AFR_MODE_AUTOREC;
   assign modeVec[`AFR_F_DC*2 +: 2] = `AFR_MODE_AUTOREC;
   assign modeVec[`AFR_F_OV*2 +: 2] = `AFR_MODE_AUTOREC;
   assign modeVec[`AFR_F_UV*2 +: 2] = `AFR_MODE_AUTOREC;
   assign modeVec[`AFR_F_CLK*2 +: 2] =
      holdMode(fault_pin_control_b[`AFR_B_HOLD_CLK]);
   assign modeVec[`AFR_F_OTW*2 +: 2] =
      holdMode(fault_pin_control_b[`AFR_B_HOLD_OTW]);
   // Auto recovery overrides the shutdown hold
   assign modeVec[`AFR_F_OTSD*2 +: 2] =
      misc_fault_control[`AFR_M_OT_AUTO_REC] ? `AFR_MODE_AUTOREC :
      holdMode(fault_pin_control_b[`AFR_B_HOLD_OTSD]);

   // One flag per fault source
   genvar gi;
   generate
      for (gi = 0; gi < `AFR_NFLT; gi = gi + 1)
      begin : gFlag
         afr_fault_flag uFlag
         (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .cond     (condVec[gi]),
            .mode     (modeVec[gi*2 +: 2]),
            .clearCmd (clearPulse),
            .flag     (flagVec[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Fault pin masking
   // ----------------------------------------
   assign maskVec[`AFR_F_OC]   = fault_pin_control_a[`AFR_A_MASK_OVERCURRENT];
   assign maskVec[`AFR_F_DC]   = fault_pin_control_a[`AFR_A_MASK_OUTPUT_DIRECT_CURRENT];
   assign maskVec[`AFR_F_OV]   = fault_pin_control_a[`AFR_A_MASK_OV];
   assign maskVec[`AFR_F_UV]   = fault_pin_control_a[`AFR_A_MASK_UV];
   assign maskVec[`AFR_F_CLK]  = fault_pin_control_a[`AFR_A_MASK_CLK];
   assign maskVec[`AFR_F_OTW]  = fault_pin_control_b[`AFR_B_MASK_OVERTEMP_WARNING];
   assign maskVec[`AFR_F_OTSD] = fault_pin_control_a[`AFR_A_MASK_OVERTEMP_SHUTDOWN];

   assign anyReport = |(flagVec & ~maskVec);

   // Sticky detect status restarts from the live level on clear
   always @*
   begin
      if (misc_fault_control[`AFR_M_CLK_DET_HOLD])
         next_clockDetectStatus = clearPulse ? clockDetect
                                  : (clockDetectStatus | clockDetect);
      else
         next_clockDetectStatus = clockDetect;
   end

   // ----------------------------------------
   // Outputs and read port
   // ----------------------------------------
   // Power stage off while any fault other than the warning is flagged
   assign stageStop = |{flagVec[`AFR_F_OTSD], flagVec[`AFR_F_CLK], flagVec[`AFR_F_UV],
                        flagVec[`AFR_F_OV], flagVec[`AFR_F_DC], flagVec[`AFR_F_OC]};

   // Read data holds its last value between reads
   always @*
   begin
      next_faultPinActive = anyReport;
      next_outputHighZ    = stageStop;
      next_regRdata       = regRdata;
      if (regRead)
      begin
         if (hit(regAddr, `AFR_OFS_PIN_CTRL_A))
            next_regRdata = fault_pin_control_a;
         else if (hit(regAddr, `AFR_OFS_PIN_CTRL_B))
            next_regRdata = fault_pin_control_b;
         else if (hit(regAddr, `AFR_OFS_MISC_CTRL))
            next_regRdata = misc_fault_control;
         else if (hit(regAddr, `AFR_OFS_STATUS))
            next_regRdata = {1'b0, flagVec};
         else
            next_regRdata = `AFR_RST_BYTE; // Clear reg is write-only
      end
   end

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         faultPinActive    <= `AFR_RST_BIT;
         outputHighZ       <= `AFR_RST_BIT;
         clockDetectStatus <= `AFR_RST_BIT;
         regRdata          <= `AFR_RST_BYTE;
      end
      else
      begin
         faultPinActive    <= next_faultPinActive;
         outputHighZ       <= next_outputHighZ;
         clockDetectStatus <= next_clockDetectStatus;
         regRdata          <= next_regRdata;
      end
   end

endmodule

//--- testbench/afr_fault_asserts.sv
// Port checker for the fault-report control block.
// Bound into afr_fault_ctrl; watches its ports only.
`timescale 1ns/1ps
module afr_fault_asserts
(
   input wire       core_clk,
   input wire       rst_b,
   input wire       regWrite,
   input wire       regRead,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire [7:0] regRdata,
   input wire       faultOvercurrent,
   input wire       faultSupplyOver,
   input wire       faultClock,
   input wire       clockDetect,
   input wire       faultPinActive,
   input wire       outputHighZ,
   input wire       clockDetectStatus
);
   reg [7:0] maskA;
   reg       detHold;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   always @(posedge core_clk)
   begin
      if (!rst_b) maskA <= 8'h00;
      else if (regWrite && regAddr == 8'h74) maskA <= regWdata;
      if (!rst_b) detHold <= 1'b0;
      else if (regWrite && regAddr == 8'h76) detHold <= regWdata[7];
   end
   a_clk_hiz: assert property ($rose(faultClock) |-> ##2 outputHighZ)
      else $error("clock fault left outputs driven");
   a_clk_pin: assert property ($rose(faultClock) ##1 !maskA[4] |-> ##1 faultPinActive)
      else $error("clock fault missing on fault pin");
   a_oc_pin: assert property ($rose(faultOvercurrent) ##1 !maskA[0] |-> ##1 faultPinActive)
      else $error("overcurrent missing on fault pin");
   a_ov_pin: assert property ($rose(faultSupplyOver) ##1 !maskA[2] |-> ##1 faultPinActive)
      else $error("overvoltage missing on fault pin");
   a_unmapped_read: assert property (regRead && regAddr == 8'h77 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_clear_read: assert property (regRead && regAddr == 8'h78 |=> regRdata == 8'h00)
      else $error("clear register read not zero");
   a_detect_follow: assert property (!detHold |=> clockDetectStatus == $past(clockDetect))
      else $error("detect status not following live");
   a_read_hold: assert property (!regRead |=> $stable(regRdata))
      else $error("read data moved without read");
endmodule
bind afr_fault_ctrl afr_fault_asserts chk
(
   .core_clk(core_clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .faultOvercurrent(faultOvercurrent), .faultSupplyOver(faultSupplyOver),
   .faultClock(faultClock), .clockDetect(clockDetect), .faultPinActive(faultPinActive),
   .outputHighZ(outputHighZ), .clockDetectStatus(clockDetectStatus)
);

//--- testbench/afr_host_model.sv
// Host software model: one-cycle byte register reads and writes.
// Drives after rising edges of core_clk; bus inverted when idle.
`timescale 1ns/1ps
module afr_host_model
(
   input  wire       core_clk,
   output reg        regWrite,
   output reg        regRead,
   output reg  [7:0] regAddr,
   output reg  [7:0] regWdata
);
   initial
   begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
   end
   task xfer(input w, input [7:0] a, input [7:0] d);
   begin
      @(posedge core_clk);
      regWrite <= w;
      regRead <= ~w;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   end
   endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench: random faults and configs against a bit model.
// Host model drives registers; fault inputs come from an xorshift source.
`timescale 1ns/1ps
module tb_top;
   reg         core_clk;
   reg         rst_b;
   reg         runF;
   reg         clockDetect;
   reg  [6:0]  flt;
   wire        regWrite;
   wire        regRead;
   wire [7:0]  regAddr;
   wire [7:0]  regWdata;
   wire [7:0]  regRdata;
   wire        faultPinActive;
   wire        outputHighZ;
   wire        clockDetectStatus;
   reg  [31:0] sf;
   reg  [31:0] sc;
   reg  [7:0]  mA;
   reg  [7:0]  mB;
   reg  [7:0]  mM;
   reg  [7:0]  mRd;
   reg  [6:0]  mf;
   reg  [6:0]  pf;
   reg  [6:0]  hold;
   reg  [6:0]  mask;
   reg         mPend;
   reg         mPin;
   reg         mHz;
   reg         mDet;
   integer     nErrors;
   integer     testsRun;
   integer     k;
   afr_host_model host (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata));
   afr_fault_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .faultOvercurrent(flt[0]), .faultOutputDc(flt[1]), .faultSupplyOver(flt[2]),
      .faultSupplyUnder(flt[3]), .faultClock(flt[4]), .warnOvertemp(flt[5]),
      .faultOvertemp(flt[6]), .clockDetect(clockDetect), .faultPinActive(faultPinActive),
      .outputHighZ(outputHighZ), .clockDetectStatus(clockDetectStatus));
   function [31:0] nx(input [31:0] x);
      reg [31:0] y;
   begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      nx = y ^ (y << 5);
   end
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
   begin
      testsRun = testsRun + 1;
      if (got !== exp)
         begin
            nErrors = nErrors + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
   end
   endtask
   task wrapUp;
   begin
      $display("errors %0d checks %0d", nErrors, testsRun);
      if (nErrors == 0 && testsRun > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   // Bit model: rise sets, clear pulse zeroes, track flags drop with cond
   always @(posedge core_clk)
   begin
      hold = {mM[4] ? 1'b0 : mB[4], mB[3], mB[5], 4'h0};
      mask = {mA[7], mB[2], mA[4], mA[3:0]};
      if (!rst_b)
         begin
            {mA, mB, mM, mRd} <= 32'h00F80000;
            {mf, pf} <= 14'h0000;
            {mPend, mPin, mHz, mDet} <= 4'h0;
         end
      else
         begin
            if (regWrite && regAddr == 8'h74) mA <= regWdata;
            if (regWrite && regAddr == 8'h75) mB <= regWdata;
            if (regWrite && regAddr == 8'h76) mM <= regWdata;
            if (regRead) mRd <= regAddr == 8'h74 ? mA : regAddr == 8'h75 ? mB :
               regAddr == 8'h76 ? mM : regAddr == 8'h79 ? {1'b0, mf} : 8'h00;
            mPend <= regWrite && regAddr == 8'h78 && regWdata[7];
            mf <= (flt & ~pf) | (mPend ? 7'h00 : mf & (hold | flt));
            pf <= flt;
            mPin <= |(mf & ~mask);
            mHz <= |(mf & 7'h5F);
            mDet <= mM[7] ? (mPend ? clockDetect : mDet | clockDetect) : clockDetect;
         end
   end
   always @(posedge core_clk)
   begin
      sf = nx(sf);
      if (runF) flt <= flt ^ (sf[6:0] & sf[13:7] & sf[20:14]);
      if (runF) clockDetect <= sf[24];
   end
   always @(negedge core_clk)
   begin
      if (rst_b)
         begin
            chk(regRdata, mRd);
            chk({7'h00, faultPinActive}, {7'h00, mPin});
            chk({7'h00, outputHighZ}, {7'h00, mHz});
            chk({7'h00, clockDetectStatus}, {7'h00, mDet});
         end
   end
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial
   begin
      #100000;
      nErrors = nErrors + 1;
      wrapUp;
   end
   initial
   begin
      {rst_b, runF, clockDetect, flt} = 10'h000;
      sf = 32'h33E4;
      sc = 32'h33E4;
      nErrors = 0;
      testsRun = 0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      for (k = 0; k < 7; k = k + 1) host.xfer(1'b0, 8'h74 + k[7:0], 8'h00);
      runF <= 1'b1;
      for (k = 0; k < 12; k = k + 1)
         begin
            sc = nx(sc);
            host.xfer(1'b1, 8'h74, k == 0 ? 8'h00 : k == 1 ? 8'hFF : sc[7:0]);
            host.xfer(1'b1, 8'h75, sc[15:8]);
            host.xfer(1'b1, 8'h76, sc[23:16]);
            host.xfer(1'b0, 8'h74 + {6'h00, sc[25:24]}, 8'h00);
            repeat (30) @(posedge core_clk);
            host.xfer(1'b0, 8'h79, 8'h00);
            host.xfer(1'b1, 8'h78, 8'h80);
            host.xfer(1'b0, 8'h79, 8'h00);
            host.xfer(1'b0, 8'h78, 8'h00);
         end
      wrapUp;
   end
endmodule
